// >>> rtl/cpc_consts.svh
// Register offsets, field positions, reset values and codes
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH

`define CPC_OFS_CTRL0      8'hea
`define CPC_OFS_CTRL1      8'heb
`define CPC_OFS_CTRL2      8'hec
`define CPC_OFS_CTRL3      8'hed
`define CPC_OFS_IRQ_MODE   8'hee
`define CPC_OFS_LINKAGE    8'hf0
`define CPC_OFS_DELAY      8'hf1

`define CPC_BIT_PEND       0
`define CPC_BIT_STATUS     1
`define CPC_BIT_IRQ_EN     2
`define CPC_BIT_ENABLE     3
`define CPC_BIT_POL        4
`define CPC_REF_LSB        5
`define CPC_REF_MSB        7

`define CPC_LINK_CMP0_BIT  0
`define CPC_LINK_HARD      2'h1
`define CPC_LINK_SOFT      2'h2

`define CPC_RST_BYTE       8'h00
`define CPC_RST_COUNT      8'h00

`endif

// >>> rtl/cpc_pkg.sv
// Types shared by the comparator control block
package cpc_pkg;

  typedef enum logic [1:0]
  {
    CPC_EDGE_RISE = 2'h0,
    CPC_EDGE_FALL = 2'h1,
    CPC_EDGE_BOTH = 2'h2,
    CPC_EDGE_ALSO = 2'h3
  } cpc_edge_t;

  typedef enum logic
  {
    CPC_DLY_IDLE,
    CPC_DLY_WAIT
  } cpc_dly_state_t;

endpackage

// >>> rtl/cpc_chan.sv
// One comparator channel: synchroniser, polarity and edge detection
`timescale 1ns/100ps

module cpc_chan
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        cmp_raw,
  input  wire logic        enable,
  input  wire logic        polarity,
  input  wire logic [1:0]  edge_mode,
  output logic             live,
  output logic             rise,
  output logic             fall,
  output logic             edge_hit
);

  logic       sync1_reg;
  logic       sync2_reg;
  logic       prev_reg;
  logic       armed_reg;
  logic       cur;
  cpc_pkg::cpc_edge_t mode;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= cmp_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign live = sync2_reg;
  assign cur  = sync2_reg ^ polarity;
  assign mode = cpc_pkg::cpc_edge_t'(edge_mode);

  // Edge history restarts whenever the channel is off
  always_ff @(posedge mclk)
  begin
    if (rst || !enable)
    begin
      prev_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      prev_reg  <= cur;
      armed_reg <= 1'b1;
    end
  end

  assign rise = enable && armed_reg && cur && !prev_reg;
  assign fall = enable && armed_reg && !cur && prev_reg;

  always_comb
  begin
    unique case (mode)
      cpc_pkg::CPC_EDGE_RISE: edge_hit = rise;
      cpc_pkg::CPC_EDGE_FALL: edge_hit = fall;
      cpc_pkg::CPC_EDGE_BOTH: edge_hit = rise || fall;
      cpc_pkg::CPC_EDGE_ALSO: edge_hit = rise || fall;
    endcase
  end

endmodule // cpc_chan

// >>> rtl/cpc_top.sv
// Comparator control, interrupt flags and PWM trigger and lock logic
`timescale 1ns/100ps
`include "cpc_consts.svh"

module cpc_top
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [3:0]  cmp_raw,
  output logic      [3:0]  cmp_enable,
  output logic      [8:0]  cmp_ref_sel,
  output logic      [3:0]  cmp_irq,
  input  wire logic        pwm_polarity,
  input  wire logic        pwm_unlock,
  input  wire logic        pwm_cycle_start,
  input  wire logic        pwm_raw_out,
  output logic             pwm_restart,
  output logic             pwm_duty_reload,
  output logic             pwm_hard_locked,
  output logic             pwm_soft_locked,
  output logic             pwm_out
);

  logic [7:0] ctrl_reg [4];
  logic [7:0] irq_mode_reg;
  logic [7:0] linkage_reg;
  logic [7:0] delay_reg;
  logic [7:0] dly_cnt_reg;
  logic [7:0] rdata_next;
  logic [3:0] live;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] edge_hit;
  logic [3:0] hard_trig;
  logic [3:0] soft_trig;
  logic       cmp0_trig;
  logic       restart_reg;
  logic       reload_reg;
  logic       hard_reg;
  logic       soft_reg;
  logic       pwm_out_reg;
  cpc_pkg::cpc_dly_state_t dly_state_reg;

  function automatic logic ctrl_hit(input logic [7:0] addr,
                                    input int         idx);
    ctrl_hit = (addr == 8'(`CPC_OFS_CTRL0 + idx));
  endfunction

  function automatic logic [1:0] link_field(input logic [7:0] link,
                                            input int         idx);
    link_field = link[2*idx -: 2];
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_chan
      cpc_chan u_chan
      (
        .mclk      (mclk),
        .rst       (rst),
        .cmp_raw   (cmp_raw[gi]),
        .enable    (ctrl_reg[gi][`CPC_BIT_ENABLE]),
        .polarity  (ctrl_reg[gi][`CPC_BIT_POL]),
        .edge_mode (irq_mode_reg[2*gi+1 -: 2]),
        .live      (live[gi]),
        .rise      (rise[gi]),
        .fall      (fall[gi]),
        .edge_hit  (edge_hit[gi])
      );

      // Control register; status bit is never stored
      always_ff @(posedge mclk)
      begin
        if (rst)
          ctrl_reg[gi] <= `CPC_RST_BYTE;
        else
        begin
          if (reg_wr && ctrl_hit(reg_addr, gi))
          begin
            ctrl_reg[gi][7:2] <= reg_wdata[7:2];
            ctrl_reg[gi][`CPC_BIT_STATUS] <= 1'b0;
          end
          // Edge sets, software clears by writing 0, set wins
          ctrl_reg[gi][`CPC_BIT_PEND] <= edge_hit[gi] ||
            (ctrl_reg[gi][`CPC_BIT_PEND] &&
             !(reg_wr && ctrl_hit(reg_addr, gi) &&
               !reg_wdata[`CPC_BIT_PEND]));
        end
      end

      assign cmp_enable[gi] = ctrl_reg[gi][`CPC_BIT_ENABLE];
      assign cmp_irq[gi]    = ctrl_reg[gi][`CPC_BIT_PEND] &&
                              ctrl_reg[gi][`CPC_BIT_IRQ_EN];

      if (gi > 0)
      begin : g_lock
        assign cmp_ref_sel[3*gi-1 -: 3] =
          ctrl_reg[gi][`CPC_REF_MSB:`CPC_REF_LSB];
        assign hard_trig[gi] = fall[gi] &&
          (link_field(linkage_reg, gi) == `CPC_LINK_HARD);
        assign soft_trig[gi] = fall[gi] &&
          (link_field(linkage_reg, gi) == `CPC_LINK_SOFT);
      end
      else
      begin : g_nolock
        assign hard_trig[gi] = 1'b0;
        assign soft_trig[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_mode_reg <= `CPC_RST_BYTE;
      linkage_reg  <= `CPC_RST_BYTE;
      delay_reg    <= `CPC_RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `CPC_OFS_IRQ_MODE)
        irq_mode_reg <= reg_wdata;
      if (reg_addr == `CPC_OFS_LINKAGE)
        linkage_reg <= reg_wdata;
      if (reg_addr == `CPC_OFS_DELAY)
        delay_reg <= reg_wdata;
    end
  end

  always_comb
  begin
    rdata_next = `CPC_RST_BYTE;
    for (int i = 0; i < 4; i++)
      if (ctrl_hit(reg_addr, i))
      begin
        rdata_next = ctrl_reg[i];
        rdata_next[`CPC_BIT_STATUS] = live[i];
      end
    if (reg_addr == `CPC_OFS_IRQ_MODE)
      rdata_next = irq_mode_reg;
    if (reg_addr == `CPC_OFS_LINKAGE)
      rdata_next = linkage_reg;
    if (reg_addr == `CPC_OFS_DELAY)
      rdata_next = delay_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= `CPC_RST_BYTE;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

  assign cmp0_trig = fall[0] && linkage_reg[`CPC_LINK_CMP0_BIT];

  // Cycle-start trigger, direct or after the programmed delay
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dly_state_reg <= cpc_pkg::CPC_DLY_IDLE;
      dly_cnt_reg   <= `CPC_RST_COUNT;
      restart_reg   <= 1'b0;
    end
    else
    begin
      restart_reg <= 1'b0;
      unique case (dly_state_reg)
        cpc_pkg::CPC_DLY_IDLE:
          if (cmp0_trig)
          begin
            if (delay_reg == `CPC_RST_COUNT)
              restart_reg <= 1'b1;
            else
            begin
              dly_cnt_reg   <= delay_reg;
              dly_state_reg <= cpc_pkg::CPC_DLY_WAIT;
            end
          end
        cpc_pkg::CPC_DLY_WAIT:
          if (dly_cnt_reg == 8'h01)
          begin
            restart_reg   <= 1'b1;
            dly_state_reg <= cpc_pkg::CPC_DLY_IDLE;
          end
          else
            dly_cnt_reg <= dly_cnt_reg - 8'h01;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      hard_reg <= 1'b0;
    else if (|hard_trig)
      hard_reg <= 1'b1;
    else if (pwm_unlock)
      hard_reg <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      soft_reg   <= 1'b0;
      reload_reg <= 1'b0;
    end
    else
    begin
      reload_reg <= |soft_trig;
      if (|soft_trig)
        soft_reg <= 1'b1;
      else if (pwm_cycle_start)
        soft_reg <= 1'b0;
    end
  end

  // Locked output holds the polarity level
  always_ff @(posedge mclk)
  begin
    if (rst)
      pwm_out_reg <= 1'b0;
    else if (hard_reg || soft_reg || (|hard_trig) || (|soft_trig))
      pwm_out_reg <= pwm_polarity;
    else
      pwm_out_reg <= pwm_raw_out;
  end

  assign pwm_restart     = restart_reg;
  assign pwm_duty_reload = reload_reg;
  assign pwm_hard_locked = hard_reg;
  assign pwm_soft_locked = soft_reg;
  assign pwm_out         = pwm_out_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  irq_gate_a: assert property (cmp_irq[0] |-> ctrl_reg[0][2])
    else $error("irq raised while its enable is off");
  pend_hold_a: assert property (ctrl_reg[1][0] && !reg_wr
                               |=> ctrl_reg[1][0])
    else $error("pending flag cleared without software");
  pend_set_a: assert property (edge_hit[2] |=> ctrl_reg[2][0])
    else $error("selected edge did not set pending");
  off_quiet_a: assert property (!ctrl_reg[3][3] |->
                                !rise[3] && !fall[3])
    else $error("disabled comparator produced an edge");
  status_live_a: assert property (reg_rd && reg_addr == 8'hea
                                  |=> reg_rdata[1] == $past(live[0]))
    else $error("status bit does not follow the input");
  status_ref_a: assert property (reg_rd && reg_addr == 8'heb
                                 |=> reg_rdata[1] == $past(live[1]))
    else $error("reference status bit does not follow the input");
  direct_trig_a: assert property (cmp0_trig && delay_reg == 8'h00 &&
                                  dly_state_reg == cpc_pkg::CPC_DLY_IDLE
                                  |=> pwm_restart)
    else $error("undelayed restart missing");
  hard_lock_a: assert property (|hard_trig |=> hard_reg ##1 pwm_out ==
                                $past(pwm_polarity))
    else $error("hard lock did not force output level");
  hard_hold_a: assert property (hard_reg && !pwm_unlock |=> hard_reg)
    else $error("hard lock released without unlock");
  soft_free_a: assert property (soft_reg && pwm_cycle_start &&
                                !(|soft_trig) |=> !soft_reg)
    else $error("soft lock not released on new cycle");
  soft_load_a: assert property (|soft_trig |=> pwm_duty_reload)
    else $error("preset duty reload missing");
  wait_quiet_a: assert property (dly_cnt_reg != 8'h01 &&
                                 dly_state_reg == cpc_pkg::CPC_DLY_WAIT
                                 |=> !pwm_restart)
    else $error("restart issued before the delay ran out");
  lock_level_a: assert property (hard_reg || soft_reg |->
                                 pwm_out == $past(pwm_polarity))
    else $error("locked output not at the polarity level");

endmodule // cpc_top

// >>> dv/cpc_pwm_model.sv
// Behavioural PWM block facing the trigger and lock lines
`timescale 1ns/100ps

module cpc_pwm_model
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pwm_restart,
  input  wire logic pol_req,
  input  wire logic unlock_req,
  input  wire logic start_req,
  output logic      pwm_polarity,
  output logic      pwm_unlock,
  output logic      pwm_cycle_start,
  output logic      pwm_raw_out
);
  logic [3:0] cnt_reg;

  // Counter restarts on a cycle-start trigger
  always @(negedge mclk)
  begin
    if (rst || pwm_restart)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end

  // Control lines follow the requests at the rising edge
  always @(posedge mclk)
  begin
    pwm_polarity    <= pol_req;
    pwm_unlock      <= unlock_req;
    pwm_cycle_start <= start_req;
  end

  assign pwm_raw_out = cnt_reg[3];
endmodule // cpc_pwm_model

// >>> dv/comparator_control_pwm_lock_tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/100ps

module comparator_control_pwm_lock_tb_top;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_rd = 1'b0;
  logic [3:0] cmp_raw = 4'h0;
  logic       pol_req = 1'b0;
  logic       unlock_req = 1'b0;
  logic       start_req = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] cmp_enable;
  logic [8:0] cmp_ref_sel;
  logic [3:0] cmp_irq;
  logic       pwm_polarity;
  logic       pwm_unlock;
  logic       pwm_cycle_start;
  logic       pwm_raw_out;
  logic       pwm_restart;
  logic       pwm_duty_reload;
  logic       pwm_hard_locked;
  logic       pwm_soft_locked;
  logic       pwm_out;
  int         n_fail = 0;
  int         num_checks = 0;
  int         t0;
  int         t3;
  // Address, write data, expected read back
  logic [7:0] rows [0:5][0:2] = '{'{8'hee, 8'h5a, 8'h5a},
    '{8'hf1, 8'h07, 8'h07}, '{8'hf0, 8'h7f, 8'h7f},
    '{8'hea, 8'hf6, 8'hf4}, '{8'hed, 8'he3, 8'he0},
    '{8'he0, 8'hff, 8'h00}};

  always #10 mclk = ~mclk;

  cpc_top uut
  (
    .mclk            (mclk),
    .rst             (rst),
    .reg_addr        (reg_addr),
    .reg_wr          (reg_wr),
    .reg_wdata       (reg_wdata),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .cmp_raw         (cmp_raw),
    .cmp_enable      (cmp_enable),
    .cmp_ref_sel     (cmp_ref_sel),
    .cmp_irq         (cmp_irq),
    .pwm_polarity    (pwm_polarity),
    .pwm_unlock      (pwm_unlock),
    .pwm_cycle_start (pwm_cycle_start),
    .pwm_raw_out     (pwm_raw_out),
    .pwm_restart     (pwm_restart),
    .pwm_duty_reload (pwm_duty_reload),
    .pwm_hard_locked (pwm_hard_locked),
    .pwm_soft_locked (pwm_soft_locked),
    .pwm_out         (pwm_out)
  );

  cpc_pwm_model u_pwm
  (
    .mclk            (mclk),
    .rst             (rst),
    .pwm_restart     (pwm_restart),
    .pol_req         (pol_req),
    .unlock_req      (unlock_req),
    .start_req       (start_req),
    .pwm_polarity    (pwm_polarity),
    .pwm_unlock      (pwm_unlock),
    .pwm_cycle_start (pwm_cycle_start),
    .pwm_raw_out     (pwm_raw_out)
  );

  task automatic results();
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk({1'b0, reg_rdata}, {1'b0, exp});
    cyc(1);
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? pwm_restart : s == 1 ? pwm_hard_locked : pwm_soft_locked;
  endfunction

  // Bounded wait for a trigger or lock output
  task automatic wait_hi(input int s, output int n);
    n = 0;
    while (pick(s) !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    if (n == 40)
    begin
      n_fail++;
      results();
    end
  endtask

  task automatic all_zero();
    for (int i = 0; i < 8; i++)
      rd(8'hea + 8'(i), 8'h00);
    chk(cmp_irq, 4'h0);
    chk({pwm_restart, pwm_duty_reload, pwm_hard_locked,
         pwm_soft_locked}, 4'h0);
  endtask

  // Fall of one comparator input after a settled high
  task automatic pulse_low(input int c);
    cmp_raw[c] = 1'b1;
    cyc(6);
    cmp_raw[c] = 1'b0;
  endtask

  initial
  begin
    cyc(2);
    rst = 1'b0;
    cyc(1);
    all_zero();
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
    end
    wr(8'hf0, 8'h00);
    wr(8'heb, 8'h0c);
    // Every edge mode on comparator 1
    for (int m = 0; m < 4; m++)
    begin
      wr(8'hee, {4'h0, 2'(m), 2'h0});
      cmp_raw[1] = 1'b1;
      cyc(6);
      rd(8'heb, {7'h07, m != 1});
      wr(8'heb, 8'h0c);
      cmp_raw[1] = 1'b0;
      cyc(6);
      chk(cmp_irq[1], m != 0);
      wr(8'heb, 8'h0c);
      rd(8'heb, 8'h0c);
    end
    wr(8'hec, 8'h14);
    wr(8'hee, 8'h00);
    pulse_low(2);
    cyc(6);
    chk(cmp_irq[2], 1'b0);
    wr(8'hec, 8'h1c);
    cyc(2);
    cmp_raw[2] = 1'b1;
    cyc(6);
    chk(cmp_irq[2], 1'b0);
    cmp_raw[2] = 1'b0;
    cyc(6);
    chk(cmp_irq[2], 1'b1);
    wr(8'hed, 8'ha8);
    chk(cmp_ref_sel, 9'h140);
    chk(cmp_enable, 4'he);
    wr(8'hea, 8'h08);
    cmp_raw[0] = 1'b1;
    cyc(6);
    rd(8'hea, 8'h0b);
    chk(cmp_irq[0], 1'b0);
    wr(8'hf0, 8'h01);
    wr(8'hf1, 8'h00);
    pulse_low(0);
    wait_hi(0, t0);
    wr(8'hf1, 8'h03);
    pulse_low(0);
    wait_hi(0, t3);
    chk(9'(t3 - t0), 9'h003);
    wr(8'hf0, 8'h02);
    pol_req = 1'b1;
    pulse_low(1);
    wait_hi(1, t0);
    cyc(8);
    chk({pwm_hard_locked, pwm_out}, 2'h3);
    unlock_req = 1'b1;
    cyc(1);
    unlock_req = 1'b0;
    cyc(3);
    chk(pwm_hard_locked, 1'b0);
    chk(pwm_out, pwm_raw_out);
    pol_req = 1'b0;
    wr(8'hf0, 8'h04);
    pulse_low(1);
    wait_hi(2, t0);
    chk({pwm_duty_reload, pwm_out}, 2'h2);
    cyc(4);
    chk(pwm_soft_locked, 1'b1);
    start_req = 1'b1;
    cyc(1);
    start_req = 1'b0;
    cyc(3);
    chk(pwm_soft_locked, 1'b0);
    wr(8'hf0, 8'h02);
    pulse_low(1);
    wait_hi(1, t0);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    all_zero();
    results();
  end
endmodule // comparator_control_pwm_lock_tb_top
